// *** uii_pkg.sv ***
// constants and helpers shared by the interrupt identification block
// Operation
// - ident bits 7:6 show 0x0 normally, 0x3 whenever the queue enable is set
// - bit 0 is the no-pending indicator; clear means an interrupt is shown
// - bits 3:1 carry the 3-bit pending source code; other codes are reserved
// - code 000, lowest priority, modem status; cleared by modem status read
// - code 001 transmit empty; cleared by transmit write or ident read
// - code 010 receive ready; non-queue clears on read, queue follows trigger level
// - code 011 line status error, highest priority; cleared by line status read
// - queue mode only: code 110 when bytes wait unaccessed for four frames
// - timeout clears on receive read, receive flush, or a new byte arriving
// - one frame is start, data bits, one parity and one stop bit
// - timeout span is 32 bit times for length 00, 36 for 01
// - timeout span is 40 bit times for length 10
// - timeout span is 44 bit times for length 11, eight data bits
// - queue enable selects queue mode; clearing it disables both queues
// - receive flush empties the receive queue; software must clear it again
// - trigger codes 0..7 select 1,2,4,6,8,10,12,14 bytes
// - receive-data enable gates both data ready and receive timeout
package uii_pkg;

  localparam int         IDENT_W        = 8;
  localparam int         MODE_LSB       = 6;
  localparam int         CODE_LSB       = 1;
  localparam int         NOPEND_BIT     = 0;
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_QUEUE     = 2'h3;
  localparam logic [2:0] CODE_MODEM     = 3'h0;
  localparam logic [2:0] CODE_TX_EMPTY  = 3'h1;
  localparam logic [2:0] CODE_RX_READY  = 3'h2;
  localparam logic [2:0] CODE_LINE_ERR  = 3'h3;
  localparam logic [2:0] CODE_TIMEOUT   = 3'h6;
  localparam logic [7:0] IDENT_RESET    = 8'h01;

  // frame = start + data + parity + stop, times four frames
  localparam int         START_BITS     = 1;
  localparam int         PARITY_BITS    = 1;
  localparam int         STOP_BITS      = 1;
  localparam int         MIN_DATA_BITS  = 5;
  localparam int         TIMEOUT_FRAMES = 4;
  localparam int         TMO_W          = 6;

  function automatic logic [TMO_W-1:0] timeout_span(input logic [1:0] word_length_select);
    int data_bits;
    data_bits = MIN_DATA_BITS + int'(word_length_select);
    timeout_span = TMO_W'((START_BITS + data_bits + PARITY_BITS + STOP_BITS)
                          * TIMEOUT_FRAMES);
  endfunction : timeout_span

  function automatic logic [4:0] trigger_bytes(input logic [2:0] sel);
    trigger_bytes = (sel == 3'h0) ? 5'h01 : {1'b0, sel, 1'b0};
  endfunction : trigger_bytes

endpackage : uii_pkg

// *** uii_rx_timeout.sv ***
// receive queue character timeout counter
`timescale 1ns/100ps
module uii_rx_timeout
  import uii_pkg::*;
(
  input  wire logic       clk,        // core clock
  input  wire logic       rst_n,      // synchronous reset, low
  input  wire logic       armed,      // queue mode with bytes waiting
  input  wire logic       restart,    // queue access or new byte
  input  wire logic       bit_tick,   // one pulse per bit time
  input  wire logic [1:0] word_length_select,        // word length select
  output logic            timeout     // timeout flag
);

  logic [TMO_W-1:0] count_ff;
  logic [TMO_W-1:0] nxt_count;
  logic             timeout_ff;
  logic             nxt_timeout;

  always_comb begin
    nxt_count   = count_ff;
    nxt_timeout = timeout_ff;
    if (restart || !armed) begin
      // any access restarts the span; disarm also drops the flag
      nxt_count   = '0;
      nxt_timeout = 1'b0;
    end else if (bit_tick && !timeout_ff) begin
      nxt_count = count_ff + TMO_W'(1);
      if (nxt_count >= timeout_span(word_length_select)) begin
        nxt_timeout = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff   <= '0;
      timeout_ff <= 1'b0;
    end else begin
      count_ff   <= nxt_count;
      timeout_ff <= nxt_timeout;
    end
  end

  assign timeout = timeout_ff;

endmodule : uii_rx_timeout

// *** uii_ident.sv ***
// interrupt identification register and source priority
`timescale 1ns/100ps
module uii_ident
#(
  parameter int FILL_W = 5                        // receive fill count width
)
(
  input  wire logic                  CLOCK,              // core clock
  input  wire logic                  RST_N,              // sync reset, low
  input  wire logic                  QUEUE_ENABLE,       // queue mode select
  input  wire logic                  RX_QUEUE_FLUSH,     // receive flush bit
  input  wire logic [2:0]            RX_TRIGGER_LEVEL,   // trigger select
  input  wire logic [1:0]            WORD_LENGTH_SELECT, // data bits code
  input  wire logic                  RX_DATA_IRQ_ENABLE, // data/timeout enable
  input  wire logic                  TX_EMPTY_IRQ_ENABLE,// transmit empty enable
  input  wire logic                  LINE_IRQ_ENABLE,    // line status enable
  input  wire logic                  MODEM_IRQ_ENABLE,   // modem status enable
  input  wire logic                  BIT_TICK,           // one pulse per bit
  input  wire logic                  LINE_ERROR_EVENT,   // line error pulse
  input  wire logic                  MODEM_CHANGE_EVENT, // modem change pulse
  input  wire logic                  TX_EMPTY,           // holding/queue empty
  input  wire logic                  RX_HOLD_FULL,       // non-queue data held
  input  wire logic [FILL_W-1:0]     RX_FILL,            // receive queue count
  input  wire logic                  RX_PUSH,            // byte entered queue
  input  wire logic                  RD_MODEM_STATUS,    // modem status read
  input  wire logic                  RD_LINE_STATUS,     // line status read
  input  wire logic                  RD_IDENT,           // ident register read
  input  wire logic                  WR_TRANSMIT,        // transmit write
  input  wire logic                  RD_RECEIVE,         // receive data read
  output logic [uii_pkg::IDENT_W-1:0] IDENT,             // ident register
  output logic                       IRQ                 // interrupt request
);
  import uii_pkg::*;

  logic                line_pend_ff;
  logic                nxt_line_pend;
  logic                modem_pend_ff;
  logic                nxt_modem_pend;
  logic                tx_pend_ff;
  logic                nxt_tx_pend;
  logic                tx_empty_ff;
  logic                nxt_tx_empty;
  logic [IDENT_W-1:0]  ident_ff;
  logic [IDENT_W-1:0]  nxt_ident;
  logic                irq_ff;
  logic                nxt_irq;
  logic                rx_ready;
  logic                timeout;
  logic                tmo_armed;
  logic                tmo_restart;
  logic                tx_shown;

  // in non-queue mode the queue logic is idle, so the timer stays disarmed
  assign tmo_armed   = QUEUE_ENABLE && !RX_QUEUE_FLUSH
                       && (RX_FILL != '0);
  assign tmo_restart = RD_RECEIVE || RX_PUSH || RX_QUEUE_FLUSH;

  uii_rx_timeout u_timeout (
    .clk      (CLOCK),
    .rst_n    (RST_N),
    .armed    (tmo_armed),
    .restart  (tmo_restart),
    .bit_tick (BIT_TICK),
    .word_length_select      (WORD_LENGTH_SELECT),
    .timeout  (timeout)
  );

  // level source: follows the holding flag or the trigger comparison
  always_comb begin
    if (QUEUE_ENABLE) begin
      rx_ready = !RX_QUEUE_FLUSH
                 && (RX_FILL >= FILL_W'(trigger_bytes(RX_TRIGGER_LEVEL)));
    end else begin
      rx_ready = RX_HOLD_FULL;
    end
  end

  // the ident read clears transmit empty only if that is what was shown
  assign tx_shown = !ident_ff[NOPEND_BIT]
                    && (ident_ff[CODE_LSB +: 3] == CODE_TX_EMPTY);

  // sticky sources: a new event in the clearing cycle wins over the clear
  always_comb begin
    nxt_tx_empty   = TX_EMPTY;
    nxt_line_pend  = line_pend_ff;
    nxt_modem_pend = modem_pend_ff;
    nxt_tx_pend    = tx_pend_ff;
    if (RD_LINE_STATUS) begin
      nxt_line_pend = 1'b0;
    end
    if (LINE_ERROR_EVENT) begin
      nxt_line_pend = 1'b1;
    end
    if (RD_MODEM_STATUS) begin
      nxt_modem_pend = 1'b0;
    end
    if (MODEM_CHANGE_EVENT) begin
      nxt_modem_pend = 1'b1;
    end
    if (WR_TRANSMIT || (RD_IDENT && tx_shown) || !TX_EMPTY) begin
      nxt_tx_pend = 1'b0;
    end
    if (TX_EMPTY && !tx_empty_ff) begin
      nxt_tx_pend = 1'b1;
    end
  end

  // priority encoder; mode bits come straight from the queue enable
  always_comb begin
    nxt_ident                        = '0;
    nxt_ident[MODE_LSB +: 2]         = QUEUE_ENABLE ? MODE_QUEUE : MODE_NORMAL;
    nxt_ident[NOPEND_BIT]            = 1'b0;
    if (LINE_IRQ_ENABLE && line_pend_ff) begin
      nxt_ident[CODE_LSB +: 3] = CODE_LINE_ERR;
    end else if (RX_DATA_IRQ_ENABLE && rx_ready) begin
      nxt_ident[CODE_LSB +: 3] = CODE_RX_READY;
    end else if (RX_DATA_IRQ_ENABLE && QUEUE_ENABLE && timeout) begin
      nxt_ident[CODE_LSB +: 3] = CODE_TIMEOUT;
    end else if (TX_EMPTY_IRQ_ENABLE && tx_pend_ff) begin
      nxt_ident[CODE_LSB +: 3] = CODE_TX_EMPTY;
    end else if (MODEM_IRQ_ENABLE && modem_pend_ff) begin
      nxt_ident[CODE_LSB +: 3] = CODE_MODEM;
    end else begin
      nxt_ident[CODE_LSB +: 3] = CODE_MODEM;
      nxt_ident[NOPEND_BIT]    = 1'b1;
    end
    nxt_irq = !nxt_ident[NOPEND_BIT];
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      line_pend_ff  <= 1'b0;
      modem_pend_ff <= 1'b0;
      tx_pend_ff    <= 1'b0;
      tx_empty_ff   <= 1'b0;
      ident_ff      <= IDENT_RESET;
      irq_ff        <= 1'b0;
    end else begin
      line_pend_ff  <= nxt_line_pend;
      modem_pend_ff <= nxt_modem_pend;
      tx_pend_ff    <= nxt_tx_pend;
      tx_empty_ff   <= nxt_tx_empty;
      ident_ff      <= nxt_ident;
      irq_ff        <= nxt_irq;
    end
  end

  assign IDENT = ident_ff;
  assign IRQ   = irq_ff;

endmodule : uii_ident

// *** uii_ident_assertions.sv ***
// concurrent checks on the identification ports
`timescale 1ns/100ps
module uii_ident_assertions
  import uii_pkg::*;
(
  input wire logic                       CLOCK,              // core clock
  input wire logic                       RST_N,              // sync reset, low
  input wire logic                       QUEUE_ENABLE,       // queue mode
  input wire logic                       RX_DATA_IRQ_ENABLE, // rx enable
  input wire logic                       LINE_IRQ_ENABLE,    // line enable
  input wire logic                       LINE_ERROR_EVENT,   // line error
  input wire logic                       RD_LINE_STATUS,     // line read
  input wire logic                       RX_HOLD_FULL,       // rx held
  input wire logic [uii_pkg::IDENT_W-1:0] IDENT,             // ident
  input wire logic                       IRQ                 // request
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // sticky source: event, then one cycle into the flag
  sequence line_seen;
    LINE_ERROR_EVENT && LINE_IRQ_ENABLE ##1 LINE_IRQ_ENABLE;
  endsequence
  sequence line_read;
    IDENT[3:1] == CODE_LINE_ERR && !IDENT[0] && RD_LINE_STATUS && !LINE_ERROR_EVENT
      ##1 !LINE_ERROR_EVENT;
  endsequence
  a_mode_queue: assert property (QUEUE_ENABLE |=> IDENT[7:6] == MODE_QUEUE)
    else $error("mode field not queue");
  a_mode_normal: assert property (!QUEUE_ENABLE |=> IDENT[7:6] == MODE_NORMAL)
    else $error("mode field not normal");
  a_irq_bit0: assert property (IRQ == !IDENT[0])
    else $error("request disagrees with bit 0");
  a_idle_code: assert property (IDENT[0] |-> IDENT[3:1] == CODE_MODEM)
    else $error("idle code not zero");
  a_code_legal: assert property (!(IDENT[3:1] inside {3'h4, 3'h5, 3'h7}))
    else $error("reserved code shown");
  a_line_first: assert property (line_seen |=> IDENT[3:1] == CODE_LINE_ERR && !IDENT[0])
    else $error("line error not shown first");
  a_line_clear: assert property (line_read |=> IDENT[3:1] != CODE_LINE_ERR || IDENT[0])
    else $error("line error not cleared");
  a_rx_ready: assert property (!QUEUE_ENABLE && RX_HOLD_FULL && RX_DATA_IRQ_ENABLE
    && !LINE_IRQ_ENABLE |=> IDENT[3:1] == CODE_RX_READY && !IDENT[0])
    else $error("receive ready not shown");
  a_rx_gate: assert property (!RX_DATA_IRQ_ENABLE |=> IDENT[3:1] != CODE_RX_READY
    && IDENT[3:1] != CODE_TIMEOUT)
    else $error("receive source not gated");
  a_tmo_queue: assert property (IDENT[3:1] == CODE_TIMEOUT |-> IDENT[7:6] == MODE_QUEUE)
    else $error("timeout outside queue mode");
endmodule : uii_ident_assertions

// *** uii_sw_model.sv ***
// software side: one register access strobe per op code
`timescale 1ns/100ps
module uii_sw_model (
  input  wire logic [2:0] op,        // 0 idle, 1..5 access kind
  output logic            rd_modem,  // modem status read
  output logic            rd_line,   // line status read
  output logic            rd_ident,  // ident read
  output logic            wr_tx,     // transmit write
  output logic            rd_rx      // receive read
);
  // one op a cycle, so strobes never overlap
  assign rd_modem = (op == 3'h1);
  assign rd_line  = (op == 3'h2);
  assign rd_ident = (op == 3'h3);
  assign wr_tx    = (op == 3'h4);
  assign rd_rx    = (op == 3'h5);
endmodule : uii_sw_model

// *** uart_interrupt_identification_tb_top.sv ***
// self-checking bench for the identification block
`timescale 1ns/100ps
module uart_interrupt_identification_tb_top;
  import uii_pkg::*;
  logic CLOCK, RST_N, qe, fl, rxe, txe, lne, mde, tick, lev, mev, txm, hold, push;
  logic [2:0] trig, op;
  logic [1:0] word_length_select;
  logic [4:0] fill;
  logic [7:0] ident;
  logic       irq, rdm, rdl, rdi, wrt, rdr;
  int         n_mismatch, n_checks;
  uii_ident i_uii_ident (.CLOCK(CLOCK), .RST_N(RST_N), .QUEUE_ENABLE(qe),
    .RX_QUEUE_FLUSH(fl), .RX_TRIGGER_LEVEL(trig), .WORD_LENGTH_SELECT(word_length_select),
    .RX_DATA_IRQ_ENABLE(rxe), .TX_EMPTY_IRQ_ENABLE(txe), .LINE_IRQ_ENABLE(lne),
    .MODEM_IRQ_ENABLE(mde), .BIT_TICK(tick), .LINE_ERROR_EVENT(lev),
    .MODEM_CHANGE_EVENT(mev), .TX_EMPTY(txm), .RX_HOLD_FULL(hold), .RX_FILL(fill),
    .RX_PUSH(push), .RD_MODEM_STATUS(rdm), .RD_LINE_STATUS(rdl), .RD_IDENT(rdi),
    .WR_TRANSMIT(wrt), .RD_RECEIVE(rdr), .IDENT(ident), .IRQ(irq));
  uii_sw_model i_uii_sw_model (.op(op), .rd_modem(rdm), .rd_line(rdl), .rd_ident(rdi),
    .wr_tx(wrt), .rd_rx(rdr));
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  task automatic step(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : step
  task automatic acc(input logic [2:0] k);
    op = k;
    step(1);
    op = 3'h0;
    step(3);
  endtask : acc
  task automatic chk(input logic [7:0] exp);
    n_checks++;
    if (ident !== exp || irq !== ~exp[0]) begin
      n_mismatch++;
      $display("MISMATCH %0t ident %h expected %h", $time, ident, exp);
    end
  endtask : chk
  // own trigger table, written out byte count by byte count
  function automatic logic [7:0] exp_q(input logic [2:0] t, input logic [4:0] f,
                                       input logic fx);
    logic [4:0] lvl;
    case (t)
      3'h0: lvl = 5'h01;
      3'h1: lvl = 5'h02;
      3'h2: lvl = 5'h04;
      3'h3: lvl = 5'h06;
      3'h4: lvl = 5'h08;
      3'h5: lvl = 5'h0A;
      3'h6: lvl = 5'h0C;
      default: lvl = 5'h0E;
    endcase
    exp_q = (f >= lvl && !fx) ? 8'hC4 : 8'hC1;
  endfunction : exp_q
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {qe, fl, rxe, txe, lne, mde, tick, lev, mev, txm, hold, push} = '0;
    trig = 3'h0; op = 3'h0; word_length_select = 2'h0; fill = 5'h00; RST_N = 1'b0;
    n_mismatch = 0; n_checks = 0;
    void'($urandom(32'hc075_8996));
    step(3); RST_N = 1'b1;
    chk(8'h01);
    lne = 1; mde = 1; txe = 1; lev = 1; mev = 1; step(1); lev = 0; mev = 0; step(3);
    chk(8'h06);
    acc(3'h2); chk(8'h00);
    acc(3'h1); chk(8'h01);
    txm = 1; step(3); chk(8'h02);
    acc(3'h3); chk(8'h01);
    txm = 0; step(1); txm = 1; step(3); chk(8'h02);
    acc(3'h4); chk(8'h01);
    lne = 0; rxe = 1; hold = 1; step(3); chk(8'h04);
    rxe = 0; step(3); chk(8'h01);
    hold = 0; rxe = 1; qe = 1;
    for (int t = 0; t < 8; t++) begin
      trig = 3'(t); fill = (t == 0) ? 5'h00 : 5'(2 * t - 1); step(3);
      chk(exp_q(trig, fill, 1'b0));
      fill = fill + 5'h01; step(3);
      chk(exp_q(trig, fill, 1'b0));
    end
    fill = 5'h01;
    for (int w = 0; w < 4; w++) begin
      word_length_select = 2'(w); push = 1; step(1); push = 0;
      repeat (31 + 4 * w) begin tick = 1; step(1); tick = 0; step(1); end
      step(2); chk(8'hC1);
      tick = 1; step(1); tick = 0; step(3); chk(8'hCC);
      // each of the three clearing causes gets a turn
      if (w == 1) begin
        acc(3'h5);
      end else begin
        fl = (w == 2);
        push = (w != 2);
        step(1);
        push = 0;
        fl = 0;
        step(3);
      end
      chk(8'hC1);
    end
    repeat (40) begin
      trig = 3'($urandom_range(7)); fill = 5'($urandom_range(16)); fl = 1'($urandom_range(1));
      step(3); chk(exp_q(trig, fill, fl));
    end
    qe = 0; fl = 0; step(3); chk(8'h01);
    end_sim();
  end
endmodule : uart_interrupt_identification_tb_top
bind uii_ident uii_ident_assertions i_chk (.CLOCK(CLOCK), .RST_N(RST_N),
  .QUEUE_ENABLE(QUEUE_ENABLE), .RX_DATA_IRQ_ENABLE(RX_DATA_IRQ_ENABLE),
  .LINE_IRQ_ENABLE(LINE_IRQ_ENABLE), .LINE_ERROR_EVENT(LINE_ERROR_EVENT),
  .RD_LINE_STATUS(RD_LINE_STATUS), .RX_HOLD_FULL(RX_HOLD_FULL), .IDENT(IDENT), .IRQ(IRQ));
